// ---- inc/sfrpd_map.svh ----
// register offsets, field layouts, reset values and decode constants of the page decoder
`ifndef SFRPD_MAP_SVH
`define SFRPD_MAP_SVH

// register addresses inside the special register space
`define SFRPD_ADDR_PAGE_SEL 8'hA7
`define SFRPD_ADDR_XRAM_PAGE 8'hAA

// page values
`define SFRPD_PAGE_DEFAULT 8'h00
`define SFRPD_PAGE_SECOND 8'h0F

// reset values and writable bit masks
`define SFRPD_PAGE_SEL_RESET 8'h00
`define SFRPD_PAGE_SEL_WMASK 8'hFF
`define SFRPD_XRAM_PAGE_RESET 8'h00
`define SFRPD_XRAM_PAGE_WMASK 8'h0F

// field positions
`define SFRPD_SPACE_BIT 7
`define SFRPD_COL_MSB 2
`define SFRPD_BIT_COL 3'h0

// registers visible identically on every page
`define SFRPD_ADDR_P0 8'h80
`define SFRPD_ADDR_SP 8'h81
`define SFRPD_ADDR_DPL 8'h82
`define SFRPD_ADDR_DPH 8'h83
`define SFRPD_ADDR_PCON 8'h87
`define SFRPD_ADDR_P1 8'h90
`define SFRPD_ADDR_P2 8'hA0
`define SFRPD_ADDR_IE 8'hA8
`define SFRPD_ADDR_CLKSEL 8'hA9
`define SFRPD_ADDR_PSW 8'hD0
`define SFRPD_ADDR_ACC 8'hE0
`define SFRPD_ADDR_EIE1 8'hE6
`define SFRPD_ADDR_EIE2 8'hE7
`define SFRPD_ADDR_B 8'hF0
`define SFRPD_ADDR_EIP1 8'hF6
`define SFRPD_ADDR_EIP2 8'hF7

`endif

// ---- inc/sfrpd_pkg.sv ----
// types shared by the page decoder files
`default_nettype none
package sfrpd_pkg;
    // where a data access is steered
    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_LOWER_RAM,
        ROUTE_SFR,
        ROUTE_UPPER_RAM
    } sfrpd_route_e;
    // one byte of register data
    typedef logic [7:0] sfrpd_byte_t;
endpackage
`default_nettype wire

// ---- logic/sfrpd_reg8.sv ----
// byte register with per-bit write mask, masked bits hold their reset value
`timescale 1ns/1ns
`default_nettype none
module sfrpd_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    // masked merge: bits outside the mask keep the constant reset value
    wire [7:0] q_nxt = (wdata & WMASK) | (RESET_VAL & ~WMASK);

    // storage, reset to a constant only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- logic/sfrpd_top.sv ----
// special register page decoder with the page select and external ram page registers
`timescale 1ns/1ns
`default_nettype none
`include "sfrpd_map.svh"
module sfrpd_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic acc_valid,
    input wire logic acc_indirect,
    input wire logic acc_write,
    input wire logic acc_bit,
    input wire logic [2:0] acc_bit_idx,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic xmove_valid,
    input wire logic xmove_use_r1,
    input wire logic [7:0] idx_r0,
    input wire logic [7:0] idx_r1,
    output var sfrpd_pkg::sfrpd_route_e route,
    output logic [4:0] sfr_row,
    output logic [2:0] sfr_col,
    output logic sfr_on_page0,
    output logic sfr_on_pagef,
    output logic sfr_all_pages,
    output logic sfr_bit_ok,
    output logic bit_refused,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [7:0] page_select,
    output logic [7:0] xram_page,
    output logic [15:0] xmove_addr,
    output logic xmove_addr_valid
);
    // access classification
    wire upper_half = acc_addr[`SFRPD_SPACE_BIT];
    wire sfr_acc = acc_valid && !acc_indirect && upper_half;
    wire upper_ram_acc = acc_valid && acc_indirect && upper_half;
    wire lower_ram_acc = acc_valid && !upper_half;

    // row base and column index of the addressed register
    wire [4:0] row_w = acc_addr[7:3];
    wire [2:0] col_w = acc_addr[`SFRPD_COL_MSB:0];
    // only column zero of each row takes single-bit operations
    wire bit_col_w = (col_w == `SFRPD_BIT_COL);

    // core registers that ignore the page select
    wire common_w = (acc_addr == `SFRPD_ADDR_PAGE_SEL)
        || (acc_addr == `SFRPD_ADDR_P0) || (acc_addr == `SFRPD_ADDR_SP)
        || (acc_addr == `SFRPD_ADDR_DPL) || (acc_addr == `SFRPD_ADDR_DPH)
        || (acc_addr == `SFRPD_ADDR_PCON) || (acc_addr == `SFRPD_ADDR_P1)
        || (acc_addr == `SFRPD_ADDR_P2) || (acc_addr == `SFRPD_ADDR_IE)
        || (acc_addr == `SFRPD_ADDR_CLKSEL) || (acc_addr == `SFRPD_ADDR_PSW)
        || (acc_addr == `SFRPD_ADDR_ACC) || (acc_addr == `SFRPD_ADDR_EIE1)
        || (acc_addr == `SFRPD_ADDR_EIE2) || (acc_addr == `SFRPD_ADDR_B)
        || (acc_addr == `SFRPD_ADDR_EIP1)
        || (acc_addr == `SFRPD_ADDR_EIP2);

    // page compare; any other page value selects no paged register
    wire page_is_default = (page_select == `SFRPD_PAGE_DEFAULT);
    wire page_is_second = (page_select == `SFRPD_PAGE_SECOND);

    // local register hits; a bit write never lands here since byte_wr
    // excludes acc_bit, while a bit read of either address still answers
    wire page_sel_hit = sfr_acc && (acc_addr == `SFRPD_ADDR_PAGE_SEL);
    wire xram_page_hit = sfr_acc && page_is_default
        && (acc_addr == `SFRPD_ADDR_XRAM_PAGE);
    wire byte_wr = acc_write && !acc_bit;
    wire page_sel_wr = page_sel_hit && byte_wr;
    wire xram_page_wr = xram_page_hit && byte_wr;
    wire local_rd = (page_sel_hit || xram_page_hit) && !acc_write;

    // read data selection, zero when nothing local is addressed
    wire [7:0] rd_data_nxt = page_sel_hit ? page_select
        : (xram_page_hit ? xram_page : 8'h00);

    // external move address: a page write in the same cycle is bypassed
    // so the move never sees a stale page (no wait state needed)
    wire [7:0] xram_masked_wdata = acc_wdata & `SFRPD_XRAM_PAGE_WMASK;
    wire [7:0] xmove_hi_nxt = xram_page_wr ? xram_masked_wdata : xram_page;
    wire [7:0] xmove_lo_nxt = xmove_use_r1 ? idx_r1 : idx_r0;

    // decode outputs, combinational select lines
    assign route = sfr_acc ? sfrpd_pkg::ROUTE_SFR
        : (upper_ram_acc ? sfrpd_pkg::ROUTE_UPPER_RAM
        : (lower_ram_acc ? sfrpd_pkg::ROUTE_LOWER_RAM
        : sfrpd_pkg::ROUTE_NONE));
    assign sfr_row = row_w;
    assign sfr_col = col_w;
    assign sfr_all_pages = sfr_acc && common_w;
    assign sfr_on_page0 = sfr_acc && !common_w && page_is_default;
    assign sfr_on_pagef = sfr_acc && !common_w && page_is_second;
    assign sfr_bit_ok = sfr_acc && bit_col_w;
    // bit operation aimed at a byte-only register is flagged; the route and page selects still assert
    assign bit_refused = sfr_acc && acc_bit && !bit_col_w;

    // page select register, full byte writable from every page
    sfrpd_reg8 #(
        .RESET_VAL(`SFRPD_PAGE_SEL_RESET),
        .WMASK(`SFRPD_PAGE_SEL_WMASK)
    ) u_page_sel (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(page_sel_wr),
        .wdata(acc_wdata),
        .q(page_select)
    );

    // external ram page register, upper nibble pinned at zero
    sfrpd_reg8 #(
        .RESET_VAL(`SFRPD_XRAM_PAGE_RESET),
        .WMASK(`SFRPD_XRAM_PAGE_WMASK)
    ) u_xram_page (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(xram_page_wr),
        .wdata(acc_wdata),
        .q(xram_page)
    );

    // registered read answer, one cycle after the access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= local_rd;
            rd_data <= local_rd ? rd_data_nxt : 8'h00;
        end
    end

    // registered external move address, one cycle after the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xmove_addr <= 16'h0000;
            xmove_addr_valid <= 1'b0;
        end else begin
            xmove_addr_valid <= xmove_valid;
            if (xmove_valid) begin
                xmove_addr <= {xmove_hi_nxt, xmove_lo_nxt};
            end
        end
    end

    // checks on the decode and the two registers
    xram_hi_zero_a: assert property (
        @(posedge clk) disable iff (!arst_n) xram_page[7:4] == 4'h0)
        else $error("page register upper nibble not zero");

    xmove_high_byte_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        xmove_valid && !xram_page_wr |=> xmove_addr_valid
            && xmove_addr[15:8] == $past(xram_page))
        else $error("move address high byte differs from page");

    xmove_low_byte_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        xmove_valid |=> xmove_addr[7:0]
            == ($past(xmove_use_r1) ? $past(idx_r1) : $past(idx_r0)))
        else $error("move address low byte from wrong index");

    xram_page_only0_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && acc_write && acc_addr == `SFRPD_ADDR_XRAM_PAGE
            && !page_is_default |=> $stable(xram_page))
        else $error("page register written off page zero");

    direct_to_sfr_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        acc_valid && !acc_indirect && acc_addr[7]
            |-> route == sfrpd_pkg::ROUTE_SFR)
        else $error("direct upper access not routed to registers");

    indirect_to_ram_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        acc_valid && acc_indirect && acc_addr[7]
            |-> route == sfrpd_pkg::ROUTE_UPPER_RAM && !sfr_bit_ok)
        else $error("indirect upper access not routed to ram");

    bit_op_refused_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && acc_bit |-> (bit_refused == (acc_addr[2:0] != 3'h0)))
        else $error("bit operation check wrong");

    default_page_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && !common_w && page_select == 8'h00
            |-> sfr_on_page0 && !sfr_on_pagef)
        else $error("default page not decoded");

    second_page_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && !common_w && page_select == 8'h0F
            |-> sfr_on_pagef && !sfr_on_page0)
        else $error("second page not decoded");

    common_regs_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && acc_addr == 8'hE0
            |-> sfr_all_pages && !sfr_on_page0 && !sfr_on_pagef)
        else $error("common register decoded as paged");

    page_sel_write_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && acc_write && !acc_bit && acc_addr == 8'hA7
            |=> page_select == $past(acc_wdata))
        else $error("page select write lost");

    row_col_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc |-> {sfr_row, 3'h0} + {5'h00, sfr_col} == acc_addr)
        else $error("row and column do not form address");

    xmove_bypass_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        xmove_valid && xram_page_wr
            |=> xmove_addr[15:8] == ($past(acc_wdata) & 8'h0F)
            && xram_page == xmove_addr[15:8])
        else $error("move did not use freshly written page");

    read_answer_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && !acc_write && acc_addr == 8'hA7
            |=> rd_valid && rd_data == $past(page_select))
        else $error("page select read wrong");

    // the page register stays silent once another page is selected
    page_rd_off0_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && !acc_write && acc_addr == 8'hAA && !page_is_default
            |=> !rd_valid)
        else $error("page register answered off page zero");

    // a bit write aimed at the byte-only page select must not land
    bit_wr_held_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_acc && acc_write && acc_bit && acc_addr == 8'hA7
            |=> $stable(page_select))
        else $error("bit write changed page select");

    // the lower half never reaches the special register space
    lower_ram_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        acc_valid && !acc_addr[7] |-> route == sfrpd_pkg::ROUTE_LOWER_RAM)
        else $error("lower access not routed to lower ram");

    // no target is selected when the core is not accessing
    idle_route_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !acc_valid |-> route == sfrpd_pkg::ROUTE_NONE)
        else $error("route shown without an access");
endmodule
`default_nettype wire

// ---- testbench/sfr_page_decode_xram_page_tb.sv ----
// self-checking bench for the page decoder and external ram page register
`timescale 1ns/1ns
`default_nettype none
module sfr_page_decode_xram_page_tb;
    logic clk = 1'b0; // 50 ns system clock
    logic arst_n = 1'b0; // held low for three cycles
    logic acc_valid, acc_indirect, acc_write, acc_bit, xmove_valid, xmove_use_r1;
    logic [2:0] acc_bit_idx, sfr_col;
    logic [7:0] acc_addr, acc_wdata, idx_r0, idx_r1, rd_data, page_select, xram_page;
    sfrpd_pkg::sfrpd_route_e route;
    logic [4:0] sfr_row;
    logic sfr_on_page0, sfr_on_pagef, sfr_all_pages, sfr_bit_ok, bit_refused;
    logic rd_valid, xmove_addr_valid;
    logic [15:0] xmove_addr;
    int error_cnt = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    sfrpd_core_model core (.clk(clk), .acc_valid(acc_valid), .acc_indirect(acc_indirect),
        .acc_write(acc_write), .acc_bit(acc_bit), .acc_bit_idx(acc_bit_idx),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .xmove_valid(xmove_valid),
        .xmove_use_r1(xmove_use_r1), .idx_r0(idx_r0), .idx_r1(idx_r1));
    sfrpd_top uut (.clk(clk), .arst_n(arst_n), .acc_valid(acc_valid),
        .acc_indirect(acc_indirect), .acc_write(acc_write), .acc_bit(acc_bit),
        .acc_bit_idx(acc_bit_idx), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .xmove_valid(xmove_valid), .xmove_use_r1(xmove_use_r1), .idx_r0(idx_r0),
        .idx_r1(idx_r1), .route(route), .sfr_row(sfr_row), .sfr_col(sfr_col),
        .sfr_on_page0(sfr_on_page0), .sfr_on_pagef(sfr_on_pagef),
        .sfr_all_pages(sfr_all_pages), .sfr_bit_ok(sfr_bit_ok), .bit_refused(bit_refused),
        .rd_data(rd_data), .rd_valid(rd_valid), .page_select(page_select),
        .xram_page(xram_page), .xmove_addr(xmove_addr), .xmove_addr_valid(xmove_addr_valid));
    // single exit point for normal end and watchdog
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // compare one settled value, four-state exact
    task chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access cycle; #1 lets that edge's updates land before sampling
    task acc(input logic ind, wr, bt, input logic [7:0] a, d);
        core.go(1'b1, ind, wr, bt, a, d, 1'b0);
        #1;
    endtask
    task idle;
        core.go(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
        #1;
    endtask
    // cut a hang short after far more cycles than the sequence needs
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(page_select, 8'h00);
        chk(xram_page, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h80, 8'h00);
        chk(route, sfrpd_pkg::ROUTE_SFR);
        chk(sfr_all_pages, 1'b1);
        acc(1'b0, 1'b0, 1'b0, 8'hFF, 8'h00);
        chk(route, sfrpd_pkg::ROUTE_SFR);
        // indirect read of the page register address must not hit it
        acc(1'b1, 1'b0, 1'b0, 8'hAA, 8'h00);
        chk(route, sfrpd_pkg::ROUTE_UPPER_RAM);
        acc(1'b0, 1'b0, 1'b0, 8'h7F, 8'h00);
        chk(route, sfrpd_pkg::ROUTE_LOWER_RAM);
        chk(rd_valid, 1'b0);
        acc(1'b0, 1'b0, 1'b0, 8'hB1, 8'h00);
        chk({sfr_on_page0, sfr_on_pagef}, 2'h2);
        // mask interrupts with a bit write before going to the second page
        acc(1'b0, 1'b1, 1'b1, 8'hA8, 8'h00);
        chk({sfr_bit_ok, bit_refused}, 2'h2);
        acc(1'b0, 1'b1, 1'b1, 8'hA7, 8'h0F);
        chk({sfr_bit_ok, bit_refused}, 2'h1);
        acc(1'b0, 1'b1, 1'b0, 8'hAA, 8'hFF);
        chk({sfr_row, sfr_col}, 8'hAA);
        chk(page_select, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'hAA, 8'h00);
        chk(xram_page, 8'h0F);
        idle();
        chk({rd_valid, rd_data}, 9'h10F);
        chk(route, sfrpd_pkg::ROUTE_NONE);
        // back-to-back short moves, index from the first then the second register
        core.go(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
        core.idx(1'b0, 8'h34, 8'h56);
        #1;
        core.go(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
        core.idx(1'b1, 8'h34, 8'h56);
        #1;
        chk({xmove_addr_valid, xmove_addr}, 17'h10F34);
        idle();
        chk({xmove_addr_valid, xmove_addr}, 17'h10F56);
        // page write and move in one cycle: the move sees the new page
        core.go(1'b1, 1'b0, 1'b1, 1'b0, 8'hAA, 8'h35, 1'b1);
        core.idx(1'b0, 8'h12, 8'h00);
        #1;
        idle();
        chk(xmove_addr, 16'h0512);
        chk(xram_page, 8'h05);
        acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h0F);
        acc(1'b0, 1'b0, 1'b0, 8'hB1, 8'h00);
        chk({sfr_on_page0, sfr_on_pagef}, 2'h1);
        acc(1'b0, 1'b1, 1'b0, 8'hAA, 8'h03);
        acc(1'b0, 1'b0, 1'b0, 8'hA8, 8'h00);
        chk(sfr_all_pages, 1'b1);
        chk(xram_page, 8'h05);
        // accumulator decodes the same on the second page
        acc(1'b0, 1'b0, 1'b0, 8'hE0, 8'h00);
        chk({sfr_all_pages, sfr_on_page0, sfr_on_pagef}, 3'h4);
        acc(1'b0, 1'b0, 1'b0, 8'hAA, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'hA7, 8'h00);
        chk(rd_valid, 1'b0);
        idle();
        chk({rd_valid, rd_data}, 9'h10F);
        // back to the default page, then unmask interrupts again
        acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h00);
        acc(1'b0, 1'b1, 1'b1, 8'hA8, 8'h80);
        chk(page_select, 8'h00);
        idle();
        // a page value outside both maps leaves only the common registers
        acc(1'b0, 1'b1, 1'b0, 8'hAA, 8'h09);
        acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h01);
        acc(1'b0, 1'b0, 1'b0, 8'hB1, 8'h00);
        chk({sfr_on_page0, sfr_on_pagef}, 2'h0);
        chk(xram_page, 8'h09);
        acc(1'b0, 1'b0, 1'b0, 8'hA7, 8'h00);
        chk(sfr_all_pages, 1'b1);
        idle();
        chk({rd_valid, rd_data}, 9'h101);
        // reset in mid-run clears both registers without waiting for a clock
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        chk(page_select, 8'h00);
        chk(xram_page, 8'h00);
        chk(xmove_addr, 16'h0000);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        acc(1'b0, 1'b0, 1'b0, 8'hB1, 8'h00);
        chk({sfr_on_page0, sfr_on_pagef}, 2'h2);
        idle();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- testbench/sfrpd_core_model.sv ----
// core-side model that issues register accesses and external moves
`timescale 1ns/1ns
`default_nettype none
module sfrpd_core_model (
    input wire logic clk,
    output logic acc_valid,
    output logic acc_indirect,
    output logic acc_write,
    output logic acc_bit,
    output logic [2:0] acc_bit_idx,
    output logic [7:0] acc_addr,
    output logic [7:0] acc_wdata,
    output logic xmove_valid,
    output logic xmove_use_r1,
    output logic [7:0] idx_r0,
    output logic [7:0] idx_r1
);
    // quiet bus at time zero, before the first instruction
    initial begin
        {acc_valid, acc_indirect, acc_write, acc_bit, xmove_valid, xmove_use_r1} = 6'h00;
        {acc_bit_idx, acc_addr, acc_wdata, idx_r0, idx_r1} = 35'h0;
    end
    // one instruction cycle; issues whatever location the caller passes, unoccupied ones such as 8'hFF too
    task go(input logic av, ind, wr, bt, input logic [7:0] a, d, input logic xv);
        @(posedge clk);
        acc_valid <= av;
        acc_indirect <= ind;
        acc_write <= wr;
        acc_bit <= bt;
        acc_bit_idx <= 3'h7; // bit 7 is the global interrupt enable
        acc_addr <= a;
        acc_wdata <= d;
        xmove_valid <= xv;
    endtask
    // index registers for the short move form, set in the same step as go
    task idx(input logic r1sel, input logic [7:0] r0, r1);
        xmove_use_r1 <= r1sel;
        idx_r0 <= r0;
        idx_r1 <= r1;
    endtask
endmodule
`default_nettype wire
